// file: hdl/jlsm_mapper.sv
`timescale 1ns/1ps
`include "jlsm_regs.svh"
module jlsm_mapper
	import jlsm_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// configuration
	input wire logic [6:0] i_link_mode_index,
	input wire logic [14:0] i_overrange_limit_zero,
	input wire logic [14:0] i_overrange_limit_one,
	// sample frame from the converter path
	input wire logic i_frame_valid,
	input wire logic [191:0] i_byp_samples,
	input wire logic [59:0] i_chan_one_inphase,
	input wire logic [59:0] i_chan_one_quad,
	input wire logic [59:0] i_chan_two_inphase,
	input wire logic [59:0] i_chan_two_quad,
	output logic o_frame_ready,
	output logic o_mode_supported,
	// octet stream to the link layer
	input wire logic i_link_ready,
	output logic o_octet_valid,
	output logic [1:0] o_octet_index,
	output logic o_frame_end,
	output logic [63:0] o_lane_set_one,
	output logic [63:0] o_lane_set_two
);

	// ----------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------

	// layout decode from the mode number
	// numbers outside the table fall to LAY_NONE and are refused
	function automatic jlsm_layout_t decode_mode(input logic [6:0] m);
		jlsm_layout_t l;
		l = LAY_NONE;
		unique case (m)
			`JLSM_M_S8_16: l = LAY_S8_16;
			`JLSM_M_D8_8: l = LAY_D8_8;
			`JLSM_M_D8_16: l = LAY_D8_16;
			`JLSM_M_C4: l = LAY_C4;
			`JLSM_M_C8: l = LAY_C8;
			`JLSM_M_C16: l = LAY_C16;
			`JLSM_M_C2: l = LAY_C2;
			`JLSM_M_S12: l = LAY_S12;
			default: l = LAY_NONE;
		endcase
		return l;
	endfunction

	// octets each lane carries per frame
	// LAY_NONE counts one octet so a stray frame still drains
	function automatic logic [2:0] frame_octets(input jlsm_layout_t l);
		logic [2:0] n;
		n = `JLSM_OCT_TWO;
		unique case (l)
			LAY_NONE, LAY_S8_16, LAY_D8_8, LAY_D8_16: begin
				n = `JLSM_OCT_ONE;
			end
			LAY_C2: n = `JLSM_OCT_FOUR;
			LAY_C4, LAY_C8, LAY_C16, LAY_S12: n = `JLSM_OCT_TWO;
		endcase
		return n;
	endfunction

	// one raw bypass sample, 12 bits wide
	function automatic logic [11:0] raw_samp(input logic [191:0] v,
			input int idx);
		return v[idx * `JLSM_S12_W +: `JLSM_S12_W];
	endfunction

	// low octet of one bypass entry, for the 8-bit layouts
	function automatic logic [7:0] raw8(input logic [191:0] v,
			input int idx);
		return v[idx * `JLSM_S12_W +: 8];
	endfunction

	// magnitude of a signed 15-bit value; -16384 still fits unsigned
	function automatic logic [14:0] mag15(input logic [14:0] x);
		return x[14] ? 15'(~x + 15'h0001) : x;
	endfunction

	// complex word: 15-bit sample in the top, limit flag in bit 0
	// strict compare: a magnitude equal to the limit leaves it low
	function automatic logic [15:0] cword(input logic [59:0] v,
			input int idx, input logic [14:0] lim);
		logic [14:0] s;
		s = v[idx * `JLSM_CPX_W +: `JLSM_CPX_W];
		return {s, mag15(s) > lim};
	endfunction

	// place the sample set of one frame onto the sixteen lanes
	function automatic jlsm_frame_t map_frame(input jlsm_layout_t l,
			input logic [191:0] byp, input logic [59:0] ci,
			input logic [59:0] cq, input logic [59:0] di,
			input logic [59:0] dq, input logic [14:0] lz,
			input logic [14:0] lo);
		jlsm_frame_t f;
		logic [47:0] pe;
		logic [47:0] po;
		f = '0;
		pe = '0;
		po = '0;
		// lanes a layout leaves unused stay at zero
		unique case (l)
			LAY_NONE: f = '0;
			LAY_S8_16: begin
				for (int k = 0; k < 8; k++) begin
					f[k][31:24] = raw8(byp, 2 * k);
					f[8 + k][31:24] = raw8(byp, 2 * k + 1);
				end
			end
			LAY_D8_8: begin
				for (int n = 0; n < 4; n++) begin
					f[n][31:24] = raw8(byp, n);
					f[8 + n][31:24] = raw8(byp, 8 + n);
				end
			end
			LAY_D8_16: begin
				for (int n = 0; n < 8; n++) begin
					f[n][31:24] = raw8(byp, n);
					f[8 + n][31:24] = raw8(byp, 8 + n);
				end
			end
			LAY_C4: begin
				f[0][31:16] = cword(ci, 0, lz);
				f[1][31:16] = cword(cq, 0, lo);
				f[8][31:16] = cword(di, 0, lz);
				f[9][31:16] = cword(dq, 0, lo);
			end
			LAY_C8: begin
				for (int n = 0; n < 2; n++) begin
					f[n][31:16] = cword(ci, n, lz);
					f[2 + n][31:16] = cword(cq, n, lo);
					f[8 + n][31:16] = cword(di, n, lz);
					f[10 + n][31:16] = cword(dq, n, lo);
				end
			end
			LAY_C16: begin
				for (int n = 0; n < 4; n++) begin
					f[n][31:16] = cword(ci, n, lz);
					f[4 + n][31:16] = cword(cq, n, lo);
					f[8 + n][31:16] = cword(di, n, lz);
					f[12 + n][31:16] = cword(dq, n, lo);
				end
			end
			LAY_C2: begin
				// in-phase in octets 0-1, quadrature in 2-3
				f[0] = {cword(ci, 0, lz), cword(cq, 0, lo)};
				f[8] = {cword(di, 0, lz), cword(dq, 0, lo)};
			end
			LAY_S12: begin
				for (int g = 0; g < 2; g++) begin
					// four samples packed MSB first
					pe = {raw_samp(byp, 8 * g), raw_samp(byp, 8 * g + 2),
						raw_samp(byp, 8 * g + 4), raw_samp(byp, 8 * g + 6)};
					po = {raw_samp(byp, 8 * g + 1), raw_samp(byp, 8 * g + 3),
						raw_samp(byp, 8 * g + 5), raw_samp(byp, 8 * g + 7)};
					for (int p = 0; p < 3; p++) begin
						f[3 * g + p][31:16] = pe[47 - 16 * p -: 16];
						f[8 + 3 * g + p][31:16] = po[47 - 16 * p -: 16];
					end
				end
			end
		endcase
		return f;
	endfunction

	// pick one octet position across all sixteen lanes
	// octet 0 is the top byte of each lane word
	function automatic logic [127:0] pick_octets(input jlsm_frame_t f,
			input logic [1:0] pos);
		logic [127:0] o;
		o = '0;
		for (int ln = 0; ln < 16; ln++) begin
			o[8 * ln +: 8] = f[ln][31 - 8 * pos -: 8];
		end
		return o;
	endfunction

	// ----------------------------------------------------------
	// reset release
	// ----------------------------------------------------------

	// every other flop except the frame buffer storage resets from the synchronised copy
	logic rst_meta_reg;
	logic rst_sync_reg;

	// async assert, two-stage release so no flop sees a runt edge
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------
	// mapping and two-entry frame buffer
	// ----------------------------------------------------------

	// two frame slots and their octet counts; pointers toggle
	jlsm_frame_t buf_frame_reg [2];
	logic [2:0] buf_oct_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic [1:0] pos_reg;

	// layout and mapped frame for the incoming sample set
	// limitation: switch modes only with the pipe empty; a frame taken
	// in the cycle after a switch to an unknown mode maps to zeros
	wire jlsm_layout_t cur_layout = decode_mode(i_link_mode_index);
	wire mode_ok = (cur_layout != LAY_NONE);
	wire jlsm_frame_t mapped = map_frame(cur_layout, i_byp_samples,
		i_chan_one_inphase, i_chan_one_quad, i_chan_two_inphase,
		i_chan_two_quad, i_overrange_limit_zero, i_overrange_limit_one);

	// handshake terms; a stalled link holds the buffer, nothing is lost
	// pop fires when a frame's last octet moves to the output flops
	wire push = i_frame_valid && o_frame_ready;
	wire have = (cnt_reg != `JLSM_CNT_RST);
	wire adv = have && (!o_octet_valid || i_link_ready);
	wire [2:0] head_oct = buf_oct_reg[rd_ptr_reg];
	wire last_oct = ({1'b0, pos_reg} == 3'(head_oct - 3'h1));
	wire pop = adv && last_oct;
	wire [127:0] head_bytes = pick_octets(buf_frame_reg[rd_ptr_reg],
		pos_reg);

	// occupancy after this cycle's push and pop
	always_comb begin
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = 2'(cnt_reg + 2'h1);
		end else if (pop && !push) begin
			cnt_next = 2'(cnt_reg - 2'h1);
		end
	end

	// buffer storage, written on accepted frames only
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			buf_frame_reg[wr_ptr_reg] <= mapped;
			buf_oct_reg[wr_ptr_reg] <= frame_octets(cur_layout);
		end
	end

	// pointers, occupancy and ready; unknown modes refuse frames
	// ready looks at cnt_next, so a full buffer never takes a third
	always_ff @(posedge i_sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= `JLSM_CNT_RST;
			o_frame_ready <= 1'b0;
			o_mode_supported <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg ^ push;
			rd_ptr_reg <= rd_ptr_reg ^ pop;
			cnt_reg <= cnt_next;
			o_frame_ready <= (cnt_next != `JLSM_BUF_DEPTH) && mode_ok;
			o_mode_supported <= mode_ok;
		end
	end

	// ----------------------------------------------------------
	// octet serialiser
	// ----------------------------------------------------------

	// octets leave in ascending order, one position per accepted beat
	// the output flops act as a third stage: a slot frees as soon as
	// its last octet is loaded, before the link has taken it
	always_ff @(posedge i_sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pos_reg <= `JLSM_POS_RST;
			o_octet_valid <= 1'b0;
			o_octet_index <= `JLSM_POS_RST;
			o_frame_end <= 1'b0;
			o_lane_set_one <= '0;
			o_lane_set_two <= '0;
		end else if (adv) begin
			pos_reg <= last_oct ? `JLSM_POS_RST : 2'(pos_reg + 2'h1);
			o_octet_valid <= 1'b1;
			o_octet_index <= pos_reg;
			o_frame_end <= last_oct;
			o_lane_set_one <= head_bytes[63:0];
			o_lane_set_two <= head_bytes[127:64];
		end else if (i_link_ready) begin
			o_octet_valid <= 1'b0;
			o_frame_end <= 1'b0;
		end
	end

endmodule

// file: hdl/jlsm_pkg.sv
package jlsm_pkg;
	// lane layouts shared by several link modes
	typedef enum logic [3:0] {
		LAY_NONE, LAY_S8_16, LAY_D8_8, LAY_D8_16, LAY_C4,
		LAY_C8, LAY_C16, LAY_C2, LAY_S12
	} jlsm_layout_t;
	// lanes 0..7 are set one, 8..15 set two; octet 0 in [31:24]
	typedef logic [15:0][31:0] jlsm_frame_t;
endpackage

// file: hdl/jlsm_regs.svh
`ifndef JLSM_REGS_SVH
`define JLSM_REGS_SVH
// Functional notes
// - 8-bit single 16-lane: even set one, odd two
// - 8-bit dual 8-lane: A set one, B two
// - 8-bit dual 16-lane: A set one, B two
// - dec4 4-lane: I lane 0, Q lane 1
// - dec4 8-lane: I lanes 0-1, Q lanes 2-3
// - dec4 16-lane: I lanes 0-3, Q lanes 4-7
// - dec8 2-lane: four octets, I then Q
// - dec8 4-lane: I lane 0, Q lane 1
// - dec8 8-lane: I lanes 0-1, Q lanes 2-3
// - dec8 16-lane: I lanes 0-3, Q lanes 4-7
// - word is sample plus limit flag, I0/Q1
// - 12-bit: four samples over three lanes, MSB first
// - 12-bit: even samples set one, odd set two
// - flag high when magnitude exceeds its limit

// ----------------------------------------------------------
// link mode numbers, grouped by lane layout
// ----------------------------------------------------------
`define JLSM_M_S8_16 7'h06, 7'h32
`define JLSM_M_D8_8 7'h07, 7'h2D
`define JLSM_M_D8_16 7'h08, 7'h33
`define JLSM_M_C4 7'h0A, 7'h25, 7'h0E, 7'h31, 7'h39, 7'h3C, 7'h43
`define JLSM_M_C8 7'h0B, 7'h2F, 7'h0F, 7'h37, 7'h3A
`define JLSM_M_C16 7'h0C, 7'h35, 7'h10
`define JLSM_M_C2 7'h0D, 7'h27, 7'h38, 7'h3B, 7'h42, 7'h44
`define JLSM_M_S12 7'h13, 7'h2A

// ----------------------------------------------------------
// field widths, frame sizes and reset values
// ----------------------------------------------------------
`define JLSM_S12_W 12
`define JLSM_CPX_W 15
`define JLSM_OCT_ONE 3'h1
`define JLSM_OCT_TWO 3'h2
`define JLSM_OCT_FOUR 3'h4
`define JLSM_BUF_DEPTH 2'h2
`define JLSM_CNT_RST 2'h0
`define JLSM_POS_RST 2'h0
`endif

// file: testbench/jlsm_link_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// link receiver model
// ------------------------------------------------------------
module jlsm_link_model (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// stall controls
	input wire logic i_hold,
	input wire logic i_slow,
	// beat stream
	input wire logic i_valid,
	input wire logic [1:0] i_index,
	input wire logic i_end,
	input wire logic [63:0] i_one,
	input wire logic [63:0] i_two,
	output logic o_ready,
	output logic [255:0] o_rx_one,
	output logic [255:0] o_rx_two,
	output int o_frames
);
	wire logic take = i_valid && o_ready;
	// slow link takes every other beat; hold stalls it outright
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ready <= 1'b0;
			o_frames <= 0;
		end else begin
			o_ready <= !i_hold && (!i_slow || !o_ready);
			if (take && i_end) o_frames <= o_frames + 1;
		end
	end
	// rebuild lanes by octet; octet zero clears stale beats
	always_ff @(posedge i_sys_clk) begin
		if (take && i_index == 2'h0) begin
			o_rx_one <= {192'h0, i_one};
			o_rx_two <= {192'h0, i_two};
		end else if (take) begin
			o_rx_one[64*i_index+:64] <= i_one;
			o_rx_two[64*i_index+:64] <= i_two;
		end
	end
endmodule

// file: testbench/jlsm_mapper_bench.sv
`timescale 1ns/1ps
`include "jlsm_regs.svh"
// ------------------------------------------------------------
// bench for the lane mapper
// ------------------------------------------------------------
module jlsm_mapper_bench;
	logic i_sys_clk, i_resetn, i_frame_valid, i_link_ready, o_frame_ready;
	logic o_mode_supported, o_octet_valid, o_frame_end, hold, slow;
	logic [6:0] i_link_mode_index;
	logic [14:0] i_overrange_limit_zero, i_overrange_limit_one;
	logic [191:0] byp;
	logic [59:0] ci, cq, di, dq;
	logic [1:0] o_octet_index;
	logic [63:0] o_lane_set_one, o_lane_set_two;
	logic [255:0] r1, r2, e1, e2;
	int frames, base, k, miscompares, n_checks;
	logic [6:0] c4[7] = '{`JLSM_M_C4};
	logic [6:0] c8[5] = '{`JLSM_M_C8};
	logic [6:0] c16[3] = '{`JLSM_M_C16};
	logic [6:0] c2[6] = '{`JLSM_M_C2};
	jlsm_mapper dut_u (.i_sys_clk, .i_resetn, .i_link_mode_index,
		.i_overrange_limit_zero, .i_overrange_limit_one, .i_frame_valid,
		.i_byp_samples(byp), .i_chan_one_inphase(ci), .i_chan_one_quad(cq),
		.i_chan_two_inphase(di), .i_chan_two_quad(dq), .o_frame_ready,
		.o_mode_supported, .i_link_ready, .o_octet_valid, .o_octet_index,
		.o_frame_end, .o_lane_set_one, .o_lane_set_two);
	jlsm_link_model link_u (.i_sys_clk, .i_resetn, .i_hold(hold),
		.i_slow(slow), .i_valid(o_octet_valid), .i_index(o_octet_index),
		.i_end(o_frame_end), .i_one(o_lane_set_one), .i_two(o_lane_set_two),
		.o_ready(i_link_ready), .o_rx_one(r1), .o_rx_two(r2),
		.o_frames(frames));
	// word = sample plus strict magnitude flag
	function automatic logic [15:0] w(input logic [14:0] s, l);
		logic [14:0] m;
		m = s[14] ? 15'h0 - s : s;
		return {s, m > l};
	endfunction
	task chk(input logic [255:0] g, x);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %0t: got %h exp %h", $time, g, x);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task put(input int l, b, input logic [15:0] x, y);
		e1[64*b+8*l+:8] = x[15:8];
		e1[64*b+64+8*l+:8] = x[7:0];
		e2[64*b+8*l+:8] = y[15:8];
		e2[64*b+64+8*l+:8] = y[7:0];
	endtask
	task setm(input logic [6:0] m);
		@(posedge i_sys_clk) #1 i_link_mode_index = m;
		repeat (3) @(posedge i_sys_clk);
		e1 = 0;
		e2 = 0;
	endtask
	// offer one frame, held until the edge that takes it
	task send;
		int t;
		@(posedge i_sys_clk) #1 i_frame_valid = 1;
		do begin
			@(negedge i_sys_clk) t = o_frame_ready;
			@(posedge i_sys_clk);
		end while (!t);
		#1 i_frame_valid = 0;
	endtask
	task rcv(input int n);
		for (int t = 0; t < 300 && frames - base < n; t++) @(negedge i_sys_clk);
		chk(frames - base, n);
		chk(r1, e1);
		chk(r2, e2);
	endtask
	task xfer;
		base = frames;
		send;
		rcv(1);
	endtask
	task t_s8(input logic [6:0] m);
		setm(m);
		for (k = 0; k < 8; k++) begin
			e1[8*k+:8] = byp[24*k+:8];
			e2[8*k+:8] = byp[24*k+12+:8];
		end
		xfer;
	endtask
	task t_dual(input int n, input logic [6:0] m);
		setm(m);
		for (k = 0; k < n; k++) begin
			e1[8*k+:8] = byp[12*k+:8];
			e2[8*k+:8] = byp[96+12*k+:8];
		end
		xfer;
	endtask
	task t_cpx(input int h, input logic [6:0] m);
		setm(m);
		for (k = 0; k < h; k++) begin
			put(k, 0, w(ci[15*k+:15], i_overrange_limit_zero),
				w(di[15*k+:15], i_overrange_limit_zero));
			put(h + k, 0, w(cq[15*k+:15], i_overrange_limit_one),
				w(dq[15*k+:15], i_overrange_limit_one));
		end
		xfer;
	endtask
	task t_c2(input logic [6:0] m);
		setm(m);
		put(0, 0, w(ci[14:0], i_overrange_limit_zero),
			w(di[14:0], i_overrange_limit_zero));
		put(0, 2, w(cq[14:0], i_overrange_limit_one),
			w(dq[14:0], i_overrange_limit_one));
		xfer;
	endtask
	task t_s12(input logic [6:0] m);
		logic [47:0] x1, x2;
		setm(m);
		for (int g = 0; g < 2; g++) begin
			for (k = 0; k < 4; k++) begin
				x1[47-12*k-:12] = byp[12*(8*g+2*k)+:12];
				x2[47-12*k-:12] = byp[12*(8*g+2*k+1)+:12];
			end
			for (k = 0; k < 3; k++) put(3*g+k, 0, x1[47-16*k-:16], x2[47-16*k-:16]);
		end
		xfer;
	endtask
	// two frames parked behind a held link, third sent while slow
	task t_stall;
		@(posedge i_sys_clk) #1 hold = 1;
		base = frames;
		byp = ~byp;
		send;
		send;
		repeat (10) @(posedge i_sys_clk);
		#1 hold = 0;
		slow = 1;
		byp = ~byp;
		send;
		rcv(3);
		slow = 0;
	endtask
	task t_bad;
		setm(7'h00);
		chk(o_mode_supported, 0);
		chk(o_frame_ready, 0);
		base = frames;
		@(posedge i_sys_clk) #1 i_frame_valid = 1;
		repeat (6) @(posedge i_sys_clk);
		#1 i_frame_valid = 0;
		chk(frames - base, 0);
		setm(7'h06);
		chk(o_mode_supported, 1);
	endtask
	// free-running clock
	initial begin
		i_sys_clk = 0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// hang guard, well past the expected run
	initial begin
		#60000;
		miscompares++;
		close_out;
	end
	// main sequence; flag samples straddle both limits
	initial begin
		i_resetn = 0;
		i_frame_valid = 0;
		hold = 0;
		slow = 0;
		i_link_mode_index = 7'h06;
		i_overrange_limit_zero = 15'h0100;
		i_overrange_limit_one = 15'h0200;
		for (k = 0; k < 16; k++) byp[12*k+:12] = {k[3:0], ~k[3:0], 4'h5 ^ k[3:0]};
		ci = {15'h00FF, 15'h0100, 15'h7F00, 15'h0101};
		cq = {15'h4000, 15'h0200, 15'h7DFF, 15'h0003};
		di = {15'h7EFF, 15'h0001, 15'h0101, 15'h3FFF};
		dq = {15'h01FF, 15'h0201, 15'h7E00, 15'h7DFF};
		repeat (3) @(posedge i_sys_clk);
		#1 i_resetn = 1;
		t_s8(7'h06);
		t_s8(7'h32);
		t_dual(4, 7'h07);
		t_dual(4, 7'h2D);
		t_stall;
		t_dual(8, 7'h08);
		t_dual(8, 7'h33);
		foreach (c4[i]) t_cpx(1, c4[i]);
		foreach (c8[i]) t_cpx(2, c8[i]);
		foreach (c16[i]) t_cpx(4, c16[i]);
		foreach (c2[i]) t_c2(c2[i]);
		t_s12(7'h13);
		t_s12(7'h2A);
		t_bad;
		close_out;
	end
endmodule

// file: testbench/jlsm_mapper_properties.sv
`timescale 1ns/1ps
`include "jlsm_regs.svh"
// ------------------------------------------------------------
// link-side checks
// ------------------------------------------------------------
module jlsm_mapper_properties (
	// clock and reset
	input logic i_sys_clk,
	input logic i_resetn,
	// observed ports
	input logic [6:0] i_link_mode_index,
	input logic i_link_ready,
	input logic o_frame_ready,
	input logic o_mode_supported,
	input logic o_octet_valid,
	input logic [1:0] o_octet_index,
	input logic o_frame_end,
	input logic [63:0] o_lane_set_one,
	input logic [63:0] o_lane_set_two
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	// layout classes; bench only changes mode with the pipe empty
	wire logic [6:0] md = i_link_mode_index;
	wire logic one8 = md inside {`JLSM_M_S8_16, `JLSM_M_D8_8, `JLSM_M_D8_16};
	wire logic two = md inside {`JLSM_M_C4, `JLSM_M_C8, `JLSM_M_C16,
		`JLSM_M_S12};
	wire logic d8 = md inside {`JLSM_M_D8_8};
	wire logic c4 = md inside {`JLSM_M_C4};
	wire logic c2 = md inside {`JLSM_M_C2};
	// a beat taken by the link
	sequence s_beat;
		o_octet_valid && i_link_ready;
	endsequence
	AST_HOLD: assert property (o_octet_valid && !i_link_ready |=>
		o_octet_valid && $stable(o_lane_set_one) && $stable(o_lane_set_two)
		&& $stable({o_octet_index, o_frame_end}))
		else $error("beat changed while stalled");
	AST_STEP: assert property (s_beat ##0 !o_frame_end |=>
		o_octet_valid && o_octet_index == $past(o_octet_index) + 2'h1)
		else $error("octet order broken");
	AST_WRAP: assert property (s_beat ##0 o_frame_end |=>
		!o_octet_valid || o_octet_index == 2'h0)
		else $error("frame does not restart at octet zero");
	AST_FIRST: assert property ($rose(o_octet_valid) |->
		o_octet_index == 2'h0) else $error("first beat not octet zero");
	AST_REFUSE: assert property (!o_mode_supported [*2] |->
		!o_frame_ready) else $error("frame taken in unknown mode");
	AST_ONEBEAT: assert property (o_octet_valid && one8 |->
		o_frame_end && o_octet_index == 2'h0)
		else $error("8-bit frame not one octet");
	AST_C2LEN: assert property (o_octet_valid && c2 |->
		o_frame_end == (o_octet_index == 2'h3))
		else $error("2-lane frame not four octets");
	AST_TWOBEAT: assert property (o_octet_valid && two |->
		o_frame_end == o_octet_index[0] && !o_octet_index[1])
		else $error("frame not two octets");
	AST_D8HI: assert property (o_octet_valid && d8 |->
		o_lane_set_one[63:32] == 32'h0 && o_lane_set_two[63:32] == 32'h0)
		else $error("unused lane driven");
	AST_C4HI: assert property (o_octet_valid && c4 |->
		o_lane_set_one[63:16] == 48'h0 && o_lane_set_two[63:16] == 48'h0)
		else $error("unused lane driven");
endmodule

bind jlsm_mapper jlsm_mapper_properties chk_u (.i_sys_clk, .i_resetn,
	.i_link_mode_index, .i_link_ready, .o_frame_ready, .o_mode_supported,
	.o_octet_valid, .o_octet_index, .o_frame_end, .o_lane_set_one,
	.o_lane_set_two);
